// ---- ckmc_cfg.svh ----
// constants for the kernel mode control block
// assumes inclusion by the design module only
`ifndef CKMC_CFG_SVH
`define CKMC_CFG_SVH
`define CKMC_MODULE_ON_BIT 0
`define CKMC_MODULE_ON_GUARD 1
`define CKMC_NOM_LSB 4
`define CKMC_NOM_GUARD 7
`define CKMC_SUM_LSB 8
`define CKMC_SUM_GUARD 11
`define CKMC_COM_LSB 12
`define CKMC_COM_GUARD 15
`define CKMC_CFG_RST 2'h0
`define CKMC_OPM_NORMAL_A 2'h0
`define CKMC_OPM_SUSPEND 2'h1
`define CKMC_OPM_CLOCK_OFF 2'h2
`define CKMC_STOP1_CODE 2'h3
`define CKMC_CLEANUP_CYC 4'h4
`endif

// ---- ckmc_far_model.sv ----
// far side: state control requests, debug suspend, node traffic
// assumes testbench commands; outputs change on clk edges and on the asynchronous rst_n reset only
`timescale 1ns/1ns
module ckmc_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic susp_cmd,
   input wire logic off_cmd,
   input wire logic [4:0] tx_cmd,
   input wire logic [4:0] node_tx_start,
   output logic suspend_req,
   output logic clock_off_req,
   output logic [4:0] node_tx_pending,
   output logic [4:0] node_in_frame,
   output logic [4:0] node_tx_bit
);
   logic [3:0] bits_left;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {suspend_req, clock_off_req, node_tx_pending, node_in_frame, bits_left} <= '0;
      end else begin
         suspend_req <= susp_cmd;
         clock_off_req <= off_cmd;
         // request kept until started
         node_tx_pending <= (node_tx_pending | tx_cmd) & ~node_tx_start;
         if (|node_tx_start) begin
            node_in_frame <= node_in_frame | node_tx_start;
            bits_left <= 4'h8;
         end else if (bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
         end else begin
            node_in_frame <= 5'h00;
         end
      end
   end
   // recessive outside frames, toggling inside
   assign node_tx_bit = ~node_in_frame | {5{bits_left[0]}};
endmodule

// ---- ckmc_kernel_mode_ctrl.sv ----
// kernel mode control for a five-node CAN controller
// assumes requests arrive from other domains; node and register inputs on clk
`timescale 1ns/1ns
`include "ckmc_cfg.svh"
module ckmc_kernel_mode_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dbg_rst_n,
   input wire logic ce,
   input wire logic suspend_req,
   input wire logic clock_off_req,
   input wire logic [4:0] node_suspend_en,
   input wire logic [4:0] node_in_frame,
   input wire logic [4:0] node_tx_pending,
   input wire logic [4:0] node_tx_bit,
   input wire ckmc_pkg::ckmc_regreq_t cfg_req,
   input wire ckmc_pkg::ckmc_regreq_t kernel_req,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   output logic [4:0] node_tx_start,
   output logic [4:0] node_tx_held,
   output logic [4:0] can_tx,
   output logic kernel_reg_ok,
   output logic module_clk_en,
   output logic [1:0] kernel_mode
);
   ckmc_pkg::ckmc_state_t s_r;
   ckmc_pkg::ckmc_state_t s_nxt;
   logic [1:0] sus_r;
   logic [1:0] sus_nxt;

   // upper bit of a kernel field set means kernel stop
   function automatic logic is_stop(input logic [1:0] m);
      is_stop = m[1];
   endfunction

   function automatic logic [1:0] upd(input logic [1:0] old, input logic [15:0] d, input int lsb, input int g);
      upd = d[g] ? d[lsb +: 2] : old;
   endfunction

   // clock-off request outranks suspend, so code 11 never stands for both
   function automatic logic [1:0] op_mode(input logic [1:0] req);
      if (req[1]) begin
         op_mode = `CKMC_OPM_CLOCK_OFF;
      end else if (req[0]) begin
         op_mode = `CKMC_OPM_SUSPEND;
      end else begin
         op_mode = `CKMC_OPM_NORMAL_A;
      end
   endfunction

   // operating code to governing field; codes 00 and 11 use the normal field
   function automatic logic [1:0] pick_cfg(input logic [1:0] opm, input logic [1:0] nom, input logic [1:0] sus,
      input logic [1:0] com);
      case (opm)
         `CKMC_OPM_SUSPEND: pick_cfg = sus;
         `CKMC_OPM_CLOCK_OFF: pick_cfg = com;
         default: pick_cfg = nom;
      endcase
   endfunction

   logic [1:0] opm_w;
   logic [1:0] sel_w;
   logic run_ok;
   logic dbg_hold;
   logic force_rec;
   wire logic [4:0] start_w;
   wire logic [4:0] held_w;
   wire logic [4:0] level_w;

   assign opm_w = op_mode(s_r.req_s2);
   assign sel_w = pick_cfg(opm_w, s_r.cfg.normal_mode_kernel_cfg, sus_r, s_r.cfg.clock_off_kernel_cfg);
   assign run_ok = (s_r.phase == ckmc_pkg::ckmc_run) && s_r.cfg.module_on_bit && !is_stop(sel_w);
   assign dbg_hold = (opm_w == `CKMC_OPM_SUSPEND);
   assign force_rec = (s_r.phase == ckmc_pkg::ckmc_stopped) || !s_r.cfg.module_on_bit;

   generate
      for (genvar n = 0; n < 5; n++) begin : g_node
         logic susp;
         assign susp = dbg_hold && node_suspend_en[n];
         // registered start blocks a repeat while the far side drops pending
         assign start_w[n] = run_ok && !susp && node_tx_pending[n] && !node_in_frame[n]
            && !s_r.tx_start[n];
         assign held_w[n] = node_tx_pending[n] && !start_w[n] && !node_in_frame[n]
            && !s_r.tx_start[n];
         // a frame on the bus may finish under suspend, not under stop
         assign level_w[n] = force_rec ? 1'b1 : node_tx_bit[n];
      end
   endgenerate

   always_comb begin
      logic [1:0] opm;
      logic [1:0] sel;
      logic stop_now;
      opm = opm_w;
      sel = 2'h0;
      stop_now = 1'b0;
      s_nxt = s_r;
      sus_nxt = sus_r;
      s_nxt.req_s1 = {clock_off_req, suspend_req};
      s_nxt.req_s2 = s_r.req_s1;
      // configuration register writes are honoured even when module is off
      if (cfg_req.wr) begin
         if (cfg_req.wdata[`CKMC_MODULE_ON_GUARD]) begin
            s_nxt.cfg.module_on_bit = cfg_req.wdata[`CKMC_MODULE_ON_BIT];
         end
         s_nxt.cfg.normal_mode_kernel_cfg = upd(s_r.cfg.normal_mode_kernel_cfg, cfg_req.wdata,
            `CKMC_NOM_LSB, `CKMC_NOM_GUARD);
         s_nxt.cfg.clock_off_kernel_cfg = upd(s_r.cfg.clock_off_kernel_cfg, cfg_req.wdata,
            `CKMC_COM_LSB, `CKMC_COM_GUARD);
         sus_nxt = upd(sus_r, cfg_req.wdata, `CKMC_SUM_LSB, `CKMC_SUM_GUARD);
      end
      s_nxt.rvalid = cfg_req.rd;
      s_nxt.rdata = 16'h0000;
      if (cfg_req.rd) begin
         s_nxt.rdata[`CKMC_MODULE_ON_BIT] = s_r.cfg.module_on_bit;
         s_nxt.rdata[`CKMC_NOM_LSB +: 2] = s_r.cfg.normal_mode_kernel_cfg;
         s_nxt.rdata[`CKMC_SUM_LSB +: 2] = sus_r;
         s_nxt.rdata[`CKMC_COM_LSB +: 2] = s_r.cfg.clock_off_kernel_cfg;
      end
      sel = sel_w;
      s_nxt.kmode = sel;
      stop_now = !s_r.cfg.module_on_bit;
      // clock kept running in normal and suspend while module on; off for clock-off or module off
      s_nxt.clk_en_out = s_r.cfg.module_on_bit && (opm != `CKMC_OPM_CLOCK_OFF);
      case (s_r.phase)
         ckmc_pkg::ckmc_run: begin
            if (stop_now) begin
               s_nxt.phase = ckmc_pkg::ckmc_stopped;
            end else if (is_stop(sel)) begin
               s_nxt.phase = ckmc_pkg::ckmc_cleanup;
               s_nxt.cnt = `CKMC_CLEANUP_CYC;
            end
         end
         ckmc_pkg::ckmc_cleanup: begin
            if (stop_now) begin
               s_nxt.phase = ckmc_pkg::ckmc_stopped;
            end else if (!is_stop(sel)) begin
               s_nxt.phase = ckmc_pkg::ckmc_run;
            end else if (s_r.cnt == 4'h1) begin
               s_nxt.phase = ckmc_pkg::ckmc_stopped;
            end else begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end
         end
         ckmc_pkg::ckmc_stopped: begin
            if (!stop_now && !is_stop(sel)) begin
               s_nxt.phase = ckmc_pkg::ckmc_run;
            end
         end
         default: begin
            s_nxt.phase = ckmc_pkg::ckmc_stopped;
         end
      endcase
      s_nxt.reg_ok = s_r.cfg.module_on_bit && (s_r.phase != ckmc_pkg::ckmc_stopped);
      s_nxt.tx_start = start_w;
      s_nxt.tx_held = held_w;
      s_nxt.tx_level = level_w;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.cfg.module_on_bit <= 1'b0;
         s_r.cfg.normal_mode_kernel_cfg <= `CKMC_CFG_RST;
         s_r.cfg.suspend_mode_kernel_cfg <= `CKMC_CFG_RST;
         s_r.cfg.clock_off_kernel_cfg <= `CKMC_CFG_RST;
         s_r.phase <= ckmc_pkg::ckmc_stopped;
         s_r.cnt <= 4'h0;
         s_r.kmode <= 2'h0;
         s_r.req_s1 <= 2'h0;
         s_r.req_s2 <= 2'h0;
         s_r.rdata <= 16'h0000;
         s_r.rvalid <= 1'b0;
         s_r.tx_start <= 5'h00;
         s_r.tx_held <= 5'h00;
         s_r.tx_level <= 5'h1f;
         s_r.clk_en_out <= 1'b0;
         s_r.reg_ok <= 1'b0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk or negedge dbg_rst_n) begin
      if (!dbg_rst_n) begin
         sus_r <= `CKMC_CFG_RST;
      end else if (ce) begin
         sus_r <= sus_nxt;
      end
   end

   assign cfg_rdata = s_r.rdata;
   assign cfg_rvalid = s_r.rvalid;
   assign node_tx_start = s_r.tx_start;
   assign node_tx_held = s_r.tx_held;
   assign can_tx = s_r.tx_level;
   assign kernel_reg_ok = s_r.reg_ok;
   assign module_clk_en = s_r.clk_en_out;
   assign kernel_mode = s_r.kmode;
endmodule

// ---- ckmc_kernel_mode_ctrl_asserts.sv ----
// assertions on the kernel mode control ports
// assumes a bind from the testbench top file
`timescale 1ns/1ns
module ckmc_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clock_off_req,
   input wire logic [4:0] node_tx_pending,
   input wire ckmc_pkg::ckmc_regreq_t cfg_req,
   input wire logic [15:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic [4:0] node_tx_start,
   input wire logic [4:0] node_tx_held,
   input wire logic [4:0] can_tx,
   input wire logic kernel_reg_ok,
   input wire logic module_clk_en
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_off_wr;
      ce && cfg_req.wr && cfg_req.wdata[1:0] == 2'h2;
   endsequence
   sequence s_quiet;
      !kernel_reg_ok && can_tx == 5'h1f;
   endsequence
   AST_RD_ANSWER: assert property (ce && cfg_req.rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_RD_ONLY: assert property (!(ce && cfg_req.rd) |=> !cfg_rvalid)
      else $error("read data without a read");
   AST_GUARD_ZERO: assert property (cfg_rvalid |-> (cfg_rdata & 16'h8882) == 16'h0000)
      else $error("guard bit read as one");
   AST_STOP_QUIET: assert property (!kernel_reg_ok |-> can_tx == 5'h1f)
      else $error("bus not recessive while stopped");
   AST_STOP_NO_START: assert property (!kernel_reg_ok [*2] |-> node_tx_start == 5'h00)
      else $error("start while stopped");
   AST_START_PENDING: assert property ($past(ce) |-> (node_tx_start & ~$past(node_tx_pending)) == 5'h00)
      else $error("start without request");
   AST_START_HELD: assert property ((node_tx_start & node_tx_held) == 5'h00)
      else $error("request both started and held");
   AST_CLOCK_OFF: assert property (clock_off_req [*5] |-> !module_clk_en)
      else $error("clock left on in clock-off");
   AST_OFF_NOW: assert property (s_off_wr |-> ##[1:2] s_quiet)
      else $error("module not off after enable cleared");
endmodule

// ---- ckmc_pkg.sv ----
// types for the kernel mode control block
// assumes ckmc_cfg.svh in the include path
package ckmc_pkg;
   typedef enum logic [1:0] {ckmc_run, ckmc_cleanup, ckmc_stopped} ckmc_phase_t;
   typedef struct packed {
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ckmc_regreq_t;
   typedef struct packed {
      logic module_on_bit;
      logic [1:0] normal_mode_kernel_cfg;
      logic [1:0] suspend_mode_kernel_cfg;
      logic [1:0] clock_off_kernel_cfg;
   } ckmc_cfg_t;
   typedef struct packed {
      ckmc_cfg_t cfg;
      ckmc_phase_t phase;
      logic [3:0] cnt;
      logic [1:0] kmode;
      logic [1:0] req_s1;
      logic [1:0] req_s2;
      logic [15:0] rdata;
      logic rvalid;
      logic [4:0] tx_start;
      logic [4:0] tx_held;
      logic [4:0] tx_level;
      logic clk_en_out;
      logic reg_ok;
   } ckmc_state_t;
endpackage

// ---- test_can_kernel_mode_control.sv ----
// bench for the kernel mode control block
// assumes package, checker and far side model compiled first
`timescale 1ns/1ns
module test_can_kernel_mode_control;
   logic clk = 1'b0, rst_n = 1'b0, dbg_rst_n = 1'b0, ce = 1'b1, susp_cmd = 1'b0, off_cmd = 1'b0;
   logic suspend_req, clock_off_req, cfg_rvalid, kernel_reg_ok, module_clk_en;
   logic [4:0] node_in_frame, node_tx_pending, node_tx_bit, node_tx_start, node_tx_held, can_tx;
   logic [4:0] node_suspend_en = 5'h1f, tx_cmd = 5'h00;
   logic [15:0] cfg_rdata;
   logic [1:0] kernel_mode;
   ckmc_pkg::ckmc_regreq_t cfg_req = '0, kernel_req = '0;
   int fail_count = 0, n_compared = 0;
   int codes [6] = '{1, 0, 3, 0, 1, 0};
   always #2 clk = ~clk;
   ckmc_kernel_mode_ctrl dut (.clk, .rst_n, .dbg_rst_n, .ce, .suspend_req, .clock_off_req, .node_suspend_en,
      .node_in_frame, .node_tx_pending, .node_tx_bit, .cfg_req, .kernel_req, .cfg_rdata, .cfg_rvalid,
      .node_tx_start, .node_tx_held, .can_tx, .kernel_reg_ok, .module_clk_en, .kernel_mode);
   ckmc_far_model far (.clk, .rst_n, .susp_cmd, .off_cmd, .tx_cmd, .node_tx_start, .suspend_req,
      .clock_off_req, .node_tx_pending, .node_in_frame, .node_tx_bit);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] d);
      @(posedge clk);
      cfg_req <= {d, 2'h2};
      @(posedge clk);
      cfg_req <= '0;
   endtask
   task automatic rd(input logic [15:0] exp);
      @(posedge clk);
      cfg_req <= {16'h0000, 2'h1};
      @(posedge clk);
      cfg_req <= '0;
      #1;
      check(cfg_rvalid ? cfg_rdata : 16'hdead, exp);
   endtask
   // sel 0 waits on register access, n on start of node n-1
   task automatic wait_for(input int sel, input logic v);
      int i;
      if (sel == 0) repeat (2) @(posedge clk);
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 ? kernel_reg_ok : node_tx_start[sel - 1]) === v) break;
      end
      if (i == 40) begin
         fail_count++;
         give_verdict();
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      dbg_rst_n <= 1'b1;
      rd(16'h0000);
      check(can_tx, 16'h001f);
      wr(16'h0003);
      wait_for(0, 1'b1);
      check(module_clk_en, 16'h0001);
      wr(16'h0030);
      rd(16'h0001);
      foreach (codes[k]) begin
         wr(16'h0080 | 16'(codes[k] << 4));
         wait_for(0, codes[k] < 2);
         check(kernel_mode, 16'(codes[k]));
      end
      wr(16'h00b0);
      wait_for(0, 1'b0);
      @(posedge clk);
      tx_cmd <= 5'h01;
      @(posedge clk);
      tx_cmd <= 5'h00;
      repeat (4) @(posedge clk);
      #1;
      check(node_tx_held, 16'h0001);
      check(node_tx_start, 16'h0000);
      wr(16'h0080);
      wait_for(1, 1'b1);
      @(posedge clk);
      node_suspend_en <= 5'h01;
      susp_cmd <= 1'b1;
      repeat (12) @(posedge clk);
      tx_cmd <= 5'h03;
      @(posedge clk);
      tx_cmd <= 5'h00;
      wait_for(2, 1'b1);
      check(node_tx_start, 16'h0002);
      check(node_tx_held, 16'h0001);
      wr(16'h0b00);
      @(posedge clk);
      susp_cmd <= 1'b1;
      wait_for(0, 1'b0);
      check(kernel_mode, 16'h0003);
      check(module_clk_en, 16'h0001);
      @(posedge clk);
      off_cmd <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check(kernel_mode, 16'h0000);
      check(module_clk_en, 16'h0000);
      @(posedge clk);
      susp_cmd <= 1'b0;
      off_cmd <= 1'b0;
      wr(16'h9092);
      wait_for(0, 1'b0);
      check(can_tx, 16'h001f);
      rd(16'h1310);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rd(16'h0300);
      @(posedge clk);
      dbg_rst_n <= 1'b0;
      @(posedge clk);
      dbg_rst_n <= 1'b1;
      rd(16'h0000);
      give_verdict();
   end
endmodule
bind ckmc_kernel_mode_ctrl ckmc_chk u_chk (.clk, .rst_n, .ce, .clock_off_req, .node_tx_pending, .cfg_req,
   .cfg_rdata, .cfg_rvalid, .node_tx_start, .node_tx_held, .can_tx, .kernel_reg_ok, .module_clk_en);
